//--- core/mrc_map.svh
`ifndef MRC_MAP_SVH
`define MRC_MAP_SVH

`define MRC_ACLK_PERIOD_NS     10
`define MRC_OFS_LEVEL          8'h00
`define MRC_OFS_CTRL           8'h04
`define MRC_OFS_STATUS         8'h08
`define MRC_OFS_CAUSE          8'h0C
`define MRC_CTRL_KEEP_ON_BIT   7
`define MRC_CTRL_LV_BIT        2
`define MRC_CTRL_LVL_BIT       1
`define MRC_CTRL_WCF_BIT       0
`define MRC_STATUS_TO_BIT      1
`define MRC_STATUS_PDF_BIT     0
`define MRC_LEVEL_POR          8'h55
`define MRC_LEVEL_2V10         8'h55
`define MRC_LEVEL_2V55         8'h33
`define MRC_LEVEL_3V15         8'h99
`define MRC_LEVEL_3V80         8'hAA
`define MRC_RESET_LOW_SPEED_INTERNAL_OSC_TICKS   2'h3
`define MRC_SETTLE_HIGH_SPEED_INTERNAL_OSC_CYC    11'h010
`define MRC_SETTLE_XTAL_CYC    11'h400
`define MRC_SETTLE_LOW_SPEED_INTERNAL_OSC_CYC    11'h002
`define MRC_RESP_OKAY          2'h0
`define MRC_RESP_SLVERR        2'h2

`endif

//--- core/mrc_pkg.sv
package mrc_pkg;

    typedef enum logic [2:0] {
        MRC_ST_POR    = 3'h1,
        MRC_ST_RUN    = 3'h2,
        MRC_ST_SETTLE = 3'h4
    } mrc_fsm_type;

    typedef enum logic [2:0] {
        MRC_CAUSE_NONE     = 3'h0,
        MRC_CAUSE_POR      = 3'h1,
        MRC_CAUSE_LV       = 3'h2,
        MRC_CAUSE_LVL      = 3'h3,
        MRC_CAUSE_WDT_RUN  = 3'h4,
        MRC_CAUSE_WDT_HALT = 3'h5,
        MRC_CAUSE_WCF      = 3'h6
    } mrc_cause_type;

    typedef enum logic [1:0] {
        MRC_SRC_HIGH_SPEED_INTERNAL_OSC = 2'h0,
        MRC_SRC_HXT  = 2'h1,
        MRC_SRC_LXT  = 2'h2,
        MRC_SRC_LOW_SPEED_INTERNAL_OSC = 2'h3
    } mrc_clksrc_type;

    typedef struct packed {
        logic          full_reset;
        logic          pc_sp_clear;
        logic          wdt_clear;
        mrc_cause_type cause;
    } mrc_cmd_type;

    typedef struct packed {
        mrc_fsm_type   fsm;
        logic [7:0]    level;
        logic          keep_on;
        logic          flag_lv;
        logic          flag_lvl;
        logic          flag_wcf;
        logic          to;
        logic          powerdown_flag;
        logic [15:0]   filt;
        logic          pend_lv;
        logic          pend_lvl;
        logic          pend_wcf;
        logic [1:0]    ticks;
        logic [10:0]   settle;
        mrc_cmd_type   cmd;
        mrc_cause_type last_cause;
        logic          run;
        logic          lvm_en;
        logic [1:0]    thr;
        logic          aw_have;
        logic [7:0]    awaddr;
        logic          w_have;
        logic [7:0]    wbyte;
        logic          wlane0;
        logic          awready;
        logic          wready;
        logic          bvalid;
        logic [1:0]    bresp;
        logic          arready;
        logic          rvalid;
        logic [31:0]   rdata;
        logic [1:0]    rresp;
    } mrc_state_type;

endpackage : mrc_pkg

//--- core/mrc_reset_ctrl.sv
// Summary of operation
// [R01] Monitor on outside power-down; supply in low band resets device and sets low-voltage flag.
// [R02] Low supply acts only after persisting beyond the filter time; shorter dips ignored.
// [R03] Level field decodes only 0x55, 0x33, 0x99, 0xAA into four thresholds.
// [R04] Any other level code resets after 2~3 slow ticks and reloads power-on value.
// [R05] Reset from bad level code sets the level fault flag.
// [R06] Genuine low supply resets after 2~3 slow ticks; level register kept.
// [R07] Level register powers up as 0x55, the lowest threshold.
// [R08] Monitor is off during power-down and back on when leaving it.
// [R09] Level fault flag cleared only by software writing zero.
// [R10] Control bits 6 to 3 read as zero.
// [R11] Watchdog timeout when running gives a full reset and sets timeout flag.
// [R12] Watchdog timeout when halted clears only PC and SP, sets timeout flag.
// [R13] After halted watchdog wake, wait 16, 1024 or 2 clocks by clock source.
// [R14] Power-on clears timeout and power-down flags; other resets update them per cause.
// [R15] Power-on clears the watchdog counter and lets it start counting.
// [R16] Power-on disables all interrupts and switches timer counters off.
// [R17] Power-on sets program counter to zero and stack pointer to top.
// [R18] Power-on makes all pins inputs and analog pins converter inputs.
// [R19] Bad watchdog control code resets after delay and sets watchdog fault flag.
// [R20] All sources merge into one reset pulse with a cause selecting init profile.
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns
`include "mrc_map.svh"
`default_nettype none

module mrc_reset_ctrl
    import mrc_pkg::*;
#(
    parameter int unsigned FILTER_CYC = 16
)
(
    // Clock and reset.
    input  wire logic           aclk,
    input  wire logic           aresetn,
    // Register bus, write channels.
    input  wire logic [7:0]     s_axi_awaddr,
    input  wire logic [2:0]     s_axi_awprot,
    input  wire logic           s_axi_awvalid,
    output logic                s_axi_awready,
    input  wire logic [31:0]    s_axi_wdata,
    input  wire logic [3:0]     s_axi_wstrb,
    input  wire logic           s_axi_wvalid,
    output logic                s_axi_wready,
    output logic [1:0]          s_axi_bresp,
    output logic                s_axi_bvalid,
    input  wire logic           s_axi_bready,
    // Register bus, read channels.
    input  wire logic [7:0]     s_axi_araddr,
    input  wire logic [2:0]     s_axi_arprot,
    input  wire logic           s_axi_arvalid,
    output logic                s_axi_arready,
    output logic [31:0]         s_axi_rdata,
    output logic [1:0]          s_axi_rresp,
    output logic                s_axi_rvalid,
    input  wire logic           s_axi_rready,
    // Analog monitor, oscillator and watchdog side.
    input  wire logic           low_supply,
    input  wire logic           low_speed_internal_osc_tick,
    input  wire logic           wdt_timeout,
    input  wire logic           wdt_ctrl_fault,
    input  wire logic           halted,
    input  wire logic           powerdown,
    input  wire mrc_clksrc_type sysclk_src,
    // Core side.
    output mrc_cmd_type         rst_cmd,
    output logic                core_run,
    output logic                lvm_enable,
    output logic [1:0]          threshold_sel,
    output logic                idle_sysclk_keep_on
);

    initial
    begin
        if (FILTER_CYC < 1 || FILTER_CYC > 65535)
        begin
            $error("FILTER_CYC must lie in 1..65535.");
        end
    end

    localparam logic [15:0] FILT_MAX = 16'(FILTER_CYC);

    mrc_state_type q;
    mrc_state_type d;
    logic          lvl_valid;
    logic          lv_event;
    logic          fire;
    logic          wr_go;
    logic          wr_ctrl;
    logic [2:0]    flag_set;
    logic [2:0]    flag_clr;

    always_comb
    begin
        d = q;
        d.cmd = '{full_reset: 1'b0, pc_sp_clear: 1'b0, wdt_clear: 1'b0,
                  cause: MRC_CAUSE_NONE};
        flag_set = 3'h0;
        flag_clr = 3'h0;

        // The threshold decode is registered so the analog side never sees a glitch.
        lvl_valid = 1'b1;
        unique case (q.level) // [R03]
            `MRC_LEVEL_2V10: d.thr = 2'h0;
            `MRC_LEVEL_2V55: d.thr = 2'h1;
            `MRC_LEVEL_3V15: d.thr = 2'h2;
            `MRC_LEVEL_3V80: d.thr = 2'h3;
            default:
            begin
                d.thr = q.thr;
                lvl_valid = 1'b0;
            end
        endcase

        d.lvm_en = !powerdown; // [R08]
        lv_event = 1'b0;
        if (powerdown || !low_supply) // [R08]
        begin
            d.filt = 16'h0000;
        end
        else if (q.filt < FILT_MAX) // [R02]
        begin
            d.filt = q.filt + 16'h0001;
            lv_event = (d.filt == FILT_MAX); // [R01]
        end

        if (q.fsm != MRC_ST_POR)
        begin
            if (lv_event)
            begin
                d.pend_lv = 1'b1; // [R06]
            end
            if (!lvl_valid)
            begin
                d.pend_lvl = 1'b1; // [R04]
            end
            if (wdt_ctrl_fault)
            begin
                d.pend_wcf = 1'b1; // [R19]
            end
        end

        // The delay counts whole slow ticks, so it lasts between two and three periods.
        fire = 1'b0;
        if (q.pend_lv || q.pend_lvl || q.pend_wcf)
        begin
            if (low_speed_internal_osc_tick)
            begin
                d.ticks = q.ticks + 2'h1;
                fire = (d.ticks == `MRC_RESET_LOW_SPEED_INTERNAL_OSC_TICKS); // [R04]
            end
        end
        else
        begin
            d.ticks = 2'h0;
        end

        unique case (q.fsm)
            MRC_ST_POR:
            begin
                d.cmd.full_reset = 1'b1; // [R16]
                d.cmd.pc_sp_clear = 1'b1; // [R17]
                d.cmd.wdt_clear = 1'b1; // [R15]
                d.cmd.cause = MRC_CAUSE_POR; // [R18]
                d.to = 1'b0; // [R14]
                d.powerdown_flag = 1'b0;
                d.run = 1'b1;
                d.fsm = MRC_ST_RUN;
            end
            MRC_ST_RUN:
            begin
                if (fire)
                begin
                    d.cmd.full_reset = 1'b1; // [R20]
                    d.cmd.pc_sp_clear = 1'b1;
                    d.cmd.wdt_clear = 1'b1;
                    d.keep_on = 1'b0;
                    if (q.pend_lvl)
                    begin
                        d.cmd.cause = MRC_CAUSE_LVL;
                        d.level = `MRC_LEVEL_POR; // [R04]
                    end
                    else if (q.pend_wcf)
                    begin
                        d.cmd.cause = MRC_CAUSE_WCF;
                    end
                    else
                    begin
                        d.cmd.cause = MRC_CAUSE_LV; // [R06]
                    end
                    flag_set = {q.pend_lv, q.pend_lvl, q.pend_wcf}; // [R05]
                    d.pend_lv = 1'b0;
                    d.pend_lvl = 1'b0;
                    d.pend_wcf = 1'b0;
                    d.ticks = 2'h0;
                end
                else if (wdt_timeout && !halted)
                begin
                    d.cmd.full_reset = 1'b1; // [R11]
                    d.cmd.pc_sp_clear = 1'b1;
                    d.cmd.wdt_clear = 1'b1;
                    d.cmd.cause = MRC_CAUSE_WDT_RUN;
                    d.keep_on = 1'b0;
                    d.to = 1'b1; // [R14]
                end
                else if (wdt_timeout && halted)
                begin
                    d.cmd.pc_sp_clear = 1'b1; // [R12]
                    d.cmd.cause = MRC_CAUSE_WDT_HALT;
                    d.to = 1'b1; // [R14]
                    d.powerdown_flag = 1'b1;
                    d.run = 1'b0;
                    d.fsm = MRC_ST_SETTLE;
                    unique case (sysclk_src) // [R13]
                        MRC_SRC_HIGH_SPEED_INTERNAL_OSC: d.settle = `MRC_SETTLE_HIGH_SPEED_INTERNAL_OSC_CYC;
                        MRC_SRC_HXT:  d.settle = `MRC_SETTLE_XTAL_CYC;
                        MRC_SRC_LXT:  d.settle = `MRC_SETTLE_XTAL_CYC;
                        MRC_SRC_LOW_SPEED_INTERNAL_OSC: d.settle = `MRC_SETTLE_LOW_SPEED_INTERNAL_OSC_CYC;
                    endcase
                end
            end
            MRC_ST_SETTLE:
            begin
                d.settle = q.settle - 11'h001; // [R13]
                if (q.settle == 11'h001)
                begin
                    d.run = 1'b1;
                    d.fsm = MRC_ST_RUN;
                end
            end
        endcase
        if (d.cmd.cause != MRC_CAUSE_NONE)
        begin
            d.last_cause = d.cmd.cause;
        end

        // Register bus: address and data are caught in either order.
        if (s_axi_awvalid && q.awready)
        begin
            d.aw_have = 1'b1;
            d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready)
        begin
            d.w_have = 1'b1;
            d.wbyte = s_axi_wdata[7:0];
            d.wlane0 = s_axi_wstrb[0];
        end
        if (s_axi_bready && q.bvalid)
        begin
            d.bvalid = 1'b0;
        end
        wr_go = q.aw_have && q.w_have && !q.bvalid;
        wr_ctrl = wr_go && q.wlane0 && (q.awaddr == `MRC_OFS_CTRL);
        if (wr_go)
        begin
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = `MRC_RESP_OKAY;
            // A level write that lands with a same-cycle full reset is dropped; the reset owns the level.
            if (q.awaddr == `MRC_OFS_LEVEL && q.wlane0 && !d.cmd.full_reset)
            begin
                d.level = q.wbyte;
            end
            else if (wr_ctrl)
            begin
                d.keep_on = q.wbyte[`MRC_CTRL_KEEP_ON_BIT];
                flag_clr = ~q.wbyte[2:0]; // [R09]
            end
            else if (q.awaddr != `MRC_OFS_LEVEL && q.awaddr != `MRC_OFS_CTRL
                     && q.awaddr != `MRC_OFS_STATUS && q.awaddr != `MRC_OFS_CAUSE)
            begin
                d.bresp = `MRC_RESP_SLVERR;
            end
        end
        // Hardware set wins over a software clear in the same cycle.
        d.flag_lv = (q.flag_lv && !flag_clr[2]) || flag_set[2]; // [R01]
        d.flag_lvl = (q.flag_lvl && !flag_clr[1]) || flag_set[1]; // [R09]
        d.flag_wcf = (q.flag_wcf && !flag_clr[0]) || flag_set[0]; // [R19]
        d.awready = !d.aw_have;
        d.wready = !d.w_have;

        if (s_axi_rready && q.rvalid)
        begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && q.arready)
        begin
            d.rvalid = 1'b1;
            d.rresp = `MRC_RESP_OKAY;
            d.rdata = 32'h0000_0000;
            unique case (s_axi_araddr)
                `MRC_OFS_LEVEL:  d.rdata[7:0] = q.level;
                `MRC_OFS_CTRL:   d.rdata[7:0] = {q.keep_on, 4'h0, q.flag_lv, // [R10]
                                                 q.flag_lvl, q.flag_wcf};
                `MRC_OFS_STATUS: d.rdata[1:0] = {q.to, q.powerdown_flag};
                `MRC_OFS_CAUSE:  d.rdata[2:0] = q.last_cause;
                default:         d.rresp = `MRC_RESP_SLVERR;
            endcase
        end
        d.arready = !d.rvalid;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q <= '0;
            q.fsm <= MRC_ST_POR;
            q.level <= `MRC_LEVEL_POR; // [R07]
            q.lvm_en <= 1'b1;
            q.cmd.cause <= MRC_CAUSE_NONE;
            q.last_cause <= MRC_CAUSE_NONE;
        end
        else
        begin
            q <= d;
        end
    end

    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign rst_cmd = q.cmd;
    assign core_run = q.run;
    assign lvm_enable = q.lvm_en;
    assign threshold_sel = q.thr;
    assign idle_sysclk_keep_on = q.keep_on;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    level_reload_a: assert property ( // [R04]
        q.cmd.full_reset && q.cmd.cause == MRC_CAUSE_LVL |-> q.level == `MRC_LEVEL_POR
        && q.flag_lvl)
        else $error("Bad level code reset did not reload level and set fault flag.");

    level_keep_a: assert property ( // [R06]
        q.cmd.full_reset && q.cmd.cause == MRC_CAUSE_LV |-> q.level == $past(q.level)
        && q.flag_lv && $past(low_speed_internal_osc_tick))
        else $error("Low-voltage reset changed level or ignored the slow tick.");

    fault_sticky_a: assert property ( // [R09]
        q.flag_lvl && !(wr_ctrl && !q.wbyte[1]) |=> q.flag_lvl)
        else $error("Level fault flag cleared without a software write of zero.");

    monitor_off_a: assert property ( // [R08]
        powerdown |=> !q.lvm_en ##0 q.filt == 16'h0000)
        else $error("Monitor active during power-down.");

    halt_wdt_a: assert property ( // [R12]
        wdt_timeout && halted && q.fsm == MRC_ST_RUN && !fire |=> q.cmd.pc_sp_clear
        && !q.cmd.full_reset && q.to && q.powerdown_flag && !q.run)
        else $error("Halted watchdog timeout did not give a partial reset.");

    run_wdt_a: assert property ( // [R11]
        wdt_timeout && !halted && q.fsm == MRC_ST_RUN && !fire |=> q.cmd.full_reset
        && q.to && q.powerdown_flag == $past(q.powerdown_flag))
        else $error("Running watchdog timeout did not give a full reset.");

    filter_time_a: assert property ( // [R02]
        $rose(q.pend_lv) |-> $past(q.filt) == FILT_MAX - 16'h0001 && $past(low_supply))
        else $error("Low supply acted on before the filter time.");

    por_flags_a: assert property ( // [R14]
        q.cmd.cause == MRC_CAUSE_POR |-> !q.to && !q.powerdown_flag && q.cmd.full_reset && q.cmd.wdt_clear)
        else $error("Power-on reset left timeout or power-down flag set.");

    decode_a: assert property ( // [R03]
        q.level == `MRC_LEVEL_3V15 |=> q.thr == 2'h2)
        else $error("Level code 0x99 not decoded to the third threshold.");

    settle_high_speed_internal_osc_a: assert property ( // [R13]
        $rose(q.fsm == MRC_ST_SETTLE) && $past(sysclk_src) == MRC_SRC_HIGH_SPEED_INTERNAL_OSC
        |-> !q.run [*8] ##1 !q.run [*8] ##1 q.run)
        else $error("High-speed oscillator wake settle was not sixteen clocks.");

endmodule : mrc_reset_ctrl

`default_nettype wire

//--- tb/mrc_core_model.sv
`timescale 1ns/1ns
`default_nettype none

module mrc_core_model
    import mrc_pkg::*;
#(
    parameter int unsigned LOW_SPEED_INTERNAL_OSC_DIV = 8
)
(
    // Clock and reset.
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Commands from the reset controller.
    input  wire mrc_cmd_type rst_cmd,
    input  wire logic        core_run,
    // Slow oscillator and observations.
    output logic             low_speed_internal_osc_tick,
    output int               full_cnt,
    output int               pcsp_cnt,
    output int               low_len,
    output mrc_cmd_type      last_cmd
);
    // The slow oscillator keeps running through reset, as a free oscillator does.
    int div_q = 0;
    int cur_q = 0;

    always_ff @(posedge aclk)
    begin
        div_q     <= (div_q >= LOW_SPEED_INTERNAL_OSC_DIV - 1) ? 0 : div_q + 1;
        low_speed_internal_osc_tick <= (div_q == LOW_SPEED_INTERNAL_OSC_DIV - 1);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            full_cnt <= 0;
            pcsp_cnt <= 0;
            last_cmd <= '0;
        end
        else if (rst_cmd.full_reset || rst_cmd.pc_sp_clear)
        begin
            last_cmd <= rst_cmd;
            full_cnt <= full_cnt + (rst_cmd.full_reset ? 1 : 0);
            pcsp_cnt <= pcsp_cnt + (rst_cmd.full_reset ? 0 : 1);
        end
    end

    // Length of each stretch in which the core is held, taken when it runs again.
    always_ff @(posedge aclk)
    begin
        if (!core_run)
            cur_q <= cur_q + 1;
        else if (cur_q != 0)
        begin
            low_len <= cur_q;
            cur_q   <= 0;
        end
    end
endmodule : mrc_core_model

`default_nettype wire

//--- tb/mcu_reset_controller_tb.sv
`timescale 1ns/1ns
`include "mrc_map.svh"
`default_nettype none

module mcu_reset_controller_tb
    import mrc_pkg::*;
;
    // Short filter and fast slow clock keep the run brief.
    localparam int FILT = 4;
    localparam int LDIV = 8;
    logic           aclk = 1'h0;
    logic           aresetn = 1'h0;
    logic [7:0]     awaddr = 8'h00;
    logic [7:0]     araddr = 8'h00;
    logic [31:0]    wdata = 32'h0;
    logic           awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic           low_supply = 1'h0, wdt_timeout = 1'h0, wdt_ctrl_fault = 1'h0;
    logic           halted = 1'h0, powerdown = 1'h0;
    mrc_clksrc_type src = MRC_SRC_HIGH_SPEED_INTERNAL_OSC;
    logic           awready, wready, bvalid, arready, rvalid, low_speed_internal_osc_tick, core_run, lvm_en, keep_on;
    logic [1:0]     bresp, rresp, thr, resp;
    logic [31:0]    rdata, rd;
    mrc_cmd_type    rst_cmd, last_cmd;
    int             full_cnt, pcsp_cnt, low_len, cyc;
    int             error_cnt = 0;
    int             checks_done = 0;

    mrc_reset_ctrl #(.FILTER_CYC(FILT)) dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .low_supply(low_supply), .low_speed_internal_osc_tick(low_speed_internal_osc_tick),
        .wdt_timeout(wdt_timeout), .wdt_ctrl_fault(wdt_ctrl_fault), .halted(halted),
        .powerdown(powerdown), .sysclk_src(src), .rst_cmd(rst_cmd), .core_run(core_run),
        .lvm_enable(lvm_en), .threshold_sel(thr), .idle_sysclk_keep_on(keep_on));

    mrc_core_model #(.LOW_SPEED_INTERNAL_OSC_DIV(LDIV)) partner (.aclk(aclk), .aresetn(aresetn),
        .rst_cmd(rst_cmd), .core_run(core_run), .low_speed_internal_osc_tick(low_speed_internal_osc_tick),
        .full_cnt(full_cnt), .pcsp_cnt(pcsp_cnt), .low_len(low_len), .last_cmd(last_cmd));

    always #(`MRC_ACLK_PERIOD_NS / 2) aclk = ~aclk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic test_done();
        if (error_cnt == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done

    // Ready is looked at on the falling edge, where it cannot be changing.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_t, w_t, b_t;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        bready  <= 1'h1;
        do
        begin
            @(negedge aclk);
            aw_t = awvalid && awready;
            w_t  = wvalid && wready;
            b_t  = bvalid;
            resp = bresp;
            @(posedge aclk);
            if (aw_t)
                awvalid <= 1'h0;
            if (w_t)
                wvalid <= 1'h0;
        end
        while (!b_t);
        bready <= 1'h0;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic ar_t, r_t;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'h1;
        rready  <= 1'h1;
        do
        begin
            @(negedge aclk);
            ar_t = arvalid && arready;
            r_t  = rvalid;
            rd   = rdata;
            resp = rresp;
            @(posedge aclk);
            if (ar_t)
                arvalid <= 1'h0;
        end
        while (!r_t);
        rready <= 1'h0;
        chk(rd, exp);
    endtask : rd_chk

    task automatic wait_rst(input bit pcsp);
        int base;
        base = pcsp ? pcsp_cnt : full_cnt;
        cyc = 0;
        while ((pcsp ? pcsp_cnt : full_cnt) == base && cyc < 2000)
        begin
            @(negedge aclk);
            cyc++;
        end
        // Return on a rising edge so that callers drive inputs there.
        @(posedge aclk);
    endtask : wait_rst

    task automatic pulse(input bit fault);
        @(posedge aclk);
        wdt_ctrl_fault <= fault;
        wdt_timeout    <= !fault;
        @(posedge aclk);
        wdt_ctrl_fault <= 1'h0;
        wdt_timeout    <= 1'h0;
    endtask : pulse

    task automatic s_power_on();
        repeat (3) @(posedge aclk);
        chk(32'(last_cmd), 32'({3'h7, MRC_CAUSE_POR}));
        chk(32'(lvm_en), 32'h1);
        rd_chk(`MRC_OFS_LEVEL, 32'h55);
        rd_chk(`MRC_OFS_STATUS, 32'h0);
        rd_chk(`MRC_OFS_CAUSE, 32'(MRC_CAUSE_POR));
        wr(`MRC_OFS_CTRL, 32'hFF);
        chk(32'(resp), 32'(`MRC_RESP_OKAY));
        rd_chk(`MRC_OFS_CTRL, 32'h80);
        chk(32'(keep_on), 32'h1);
        rd_chk(8'h10, 32'h0);
        chk(32'(resp), 32'(`MRC_RESP_SLVERR));
        wr(8'h10, 32'h0);
        chk(32'(resp), 32'(`MRC_RESP_SLVERR));
        wr(`MRC_OFS_CTRL, 32'h00);
    endtask : s_power_on

    task automatic s_levels();
        logic [7:0] codes[4] = '{`MRC_LEVEL_2V10, `MRC_LEVEL_2V55, `MRC_LEVEL_3V15,
                                 `MRC_LEVEL_3V80};
        for (int i = 0; i < 4; i++)
        begin
            wr(`MRC_OFS_LEVEL, 32'(codes[i]));
            rd_chk(`MRC_OFS_LEVEL, 32'(codes[i]));
            chk(32'(thr), 32'(i));
        end
        wr(`MRC_OFS_LEVEL, 32'h3C);
        wait_rst(1'h0);
        chk(32'(cyc >= 2 * LDIV - 2 && cyc <= 3 * LDIV + 3), 32'h1);
        rd_chk(`MRC_OFS_LEVEL, 32'h55);
        rd_chk(`MRC_OFS_CAUSE, 32'(MRC_CAUSE_LVL));
        wr(`MRC_OFS_CTRL, 32'h07);
        rd_chk(`MRC_OFS_CTRL, 32'h02);
        wr(`MRC_OFS_CTRL, 32'h00);
        rd_chk(`MRC_OFS_CTRL, 32'h00);
    endtask : s_levels

    task automatic s_low_supply();
        int base;
        wr(`MRC_OFS_LEVEL, 32'h99);
        base = full_cnt;
        @(posedge aclk);
        low_supply <= 1'h1;
        repeat (FILT - 1) @(posedge aclk);
        low_supply <= 1'h0;
        repeat (40) @(posedge aclk);
        chk(32'(full_cnt), 32'(base));
        low_supply <= 1'h1;
        wait_rst(1'h0);
        low_supply <= 1'h0;
        chk(32'(cyc >= FILT + 2 * LDIV - 1 && cyc <= FILT + 3 * LDIV + 3), 32'h1);
        rd_chk(`MRC_OFS_CTRL, 32'h04);
        rd_chk(`MRC_OFS_LEVEL, 32'h99);
        rd_chk(`MRC_OFS_STATUS, 32'h0);
        wr(`MRC_OFS_CTRL, 32'h00);
        powerdown <= 1'h1;
        repeat (2) @(posedge aclk);
        chk(32'(lvm_en), 32'h0);
        base = full_cnt;
        low_supply <= 1'h1;
        repeat (60) @(posedge aclk);
        chk(32'(full_cnt), 32'(base));
        low_supply <= 1'h0;
        powerdown  <= 1'h0;
        repeat (2) @(posedge aclk);
        chk(32'(lvm_en), 32'h1);
    endtask : s_low_supply

    task automatic s_watchdog();
        mrc_clksrc_type srcs[4] = '{MRC_SRC_HIGH_SPEED_INTERNAL_OSC, MRC_SRC_HXT, MRC_SRC_LXT, MRC_SRC_LOW_SPEED_INTERNAL_OSC};
        int settle[4] = '{`MRC_SETTLE_HIGH_SPEED_INTERNAL_OSC_CYC, `MRC_SETTLE_XTAL_CYC, `MRC_SETTLE_XTAL_CYC,
                          `MRC_SETTLE_LOW_SPEED_INTERNAL_OSC_CYC};
        int base;
        pulse(1'h0);
        wait_rst(1'h0);
        chk(32'(cyc < 10), 32'h1);
        rd_chk(`MRC_OFS_CAUSE, 32'(MRC_CAUSE_WDT_RUN));
        rd_chk(`MRC_OFS_STATUS, 32'h2);
        pulse(1'h1);
        wait_rst(1'h0);
        rd_chk(`MRC_OFS_CTRL, 32'h01);
        rd_chk(`MRC_OFS_CAUSE, 32'(MRC_CAUSE_WCF));
        wr(`MRC_OFS_CTRL, 32'h00);
        rd_chk(`MRC_OFS_CTRL, 32'h00);
        halted <= 1'h1;
        for (int i = 0; i < 4; i++)
        begin
            src  <= srcs[i];
            base = full_cnt;
            pulse(1'h0);
            wait_rst(1'h1);
            cyc = 0;
            while (core_run !== 1'h1 && cyc < 2000)
            begin
                @(negedge aclk);
                cyc++;
            end
            @(negedge aclk);
            chk(32'(low_len), 32'(settle[i]));
            chk(32'(full_cnt), 32'(base));
            rd_chk(`MRC_OFS_STATUS, 32'h3);
            rd_chk(`MRC_OFS_CAUSE, 32'(MRC_CAUSE_WDT_HALT));
        end
        halted <= 1'h0;
    endtask : s_watchdog

    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        s_power_on();
        s_levels();
        s_low_supply();
        s_watchdog();
        test_done();
    end

    // The whole sequence needs some two and a half thousand cycles.
    initial
    begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        test_done();
    end
endmodule : mcu_reset_controller_tb

`default_nettype wire
